/* design/cstob_divider.sv */
`timescale 1ns/1ps
// sequential restoring divider for the line impedance quotient
module cstob_divider
(
  // clock and control
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_start,
  // operands
  input wire logic [7:0] i_num,
  input wire logic [7:0] i_den,
  // result
  output logic [7:0] o_quot,
  output logic o_done
);

  logic [7:0] quot_r, quot_nxt; // quotient register, read out directly
  logic [7:0] work_r, work_nxt; // shifting dividend
  logic [8:0] rem_r, rem_nxt; // partial remainder
  logic [7:0] den_r, den_nxt; // latched divisor
  logic [3:0] cnt_r, cnt_nxt; // bits left, zero means idle
  logic done_r, done_nxt; // one-cycle done pulse

  // ---------------------------------------------------------------
  // next state: one quotient bit per enabled cycle
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [8:0] trial;
    trial = 9'h000;
    quot_nxt = quot_r;
    work_nxt = work_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (cnt_r == 4'h0)
    begin
      // idle: accept a new operand pair
      if (i_start)
      begin
        work_nxt = i_num;
        den_nxt = i_den;
        rem_nxt = 9'h000;
        cnt_nxt = 4'h8;
      end
    end
    else
    begin
      trial = {rem_r[7:0], work_r[7]};
      work_nxt = {work_r[6:0], 1'b0};
      if (trial >= {1'b0, den_r})
      begin
        rem_nxt = trial - {1'b0, den_r};
        work_nxt[0] = 1'b1;
      end
      else
      begin
        rem_nxt = trial;
      end
      cnt_nxt = cnt_r - 4'h1;
      if (cnt_r == 4'h1)
      begin
        // zero divisor saturates rather than returning garbage
        quot_nxt = (den_r == 8'h00) ? 8'hFF : work_nxt;
        done_nxt = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      quot_r <= 8'h00;
      work_r <= 8'h00;
      rem_r <= 9'h000;
      den_r <= 8'h00;
      cnt_r <= 4'h0;
      done_r <= 1'b0;
    end
    else if (i_ce)
    begin
      quot_r <= quot_nxt;
      work_r <= work_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_quot = quot_r;
  assign o_done = done_r;

endmodule

/* design/cstob_pkg.sv */
package cstob_pkg;

  // ---------------------------------------------------------------
  // register map (word index, byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_LINE_IMP_IDX = 8'h1F;
  localparam logic [7:0] REG_GAIN_TRIM_IDX = 8'h21;
  localparam logic [7:0] REG_OCP_LIMIT_IDX = 8'h22;
  localparam logic [7:0] REG_CTRL_IDX = 8'h30;
  localparam logic [7:0] REG_STATUS_IDX = 8'h31;
  localparam int ADDR_W = 10;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int TRIM_POL_BIT = 7;
  localparam int BLANK_LSB = 5;
  localparam int CTRL_AUX_BIT = 0;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [7:0] OCP_LIMIT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  // ---------------------------------------------------------------
  // timing: blanking delays in ns per code, clock period in ns
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int BLANK_NS_1 = 40;
  localparam int BLANK_NS_2 = 80;
  localparam int BLANK_NS_3 = 120;
  localparam int BLANK_NS_4 = 200;
  localparam int BLANK_NS_5 = 400;
  localparam int BLANK_NS_6 = 600;
  localparam int BLANK_NS_7 = 800;
  localparam int CNT_W = 6;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] local_v;
    logic [7:0] remote_v;
    logic [7:0] current;
  } cstob_sense_t;

  typedef struct packed
  {
    logic negative;
    logic [6:0] magnitude;
  } cstob_trim_t;

  typedef enum logic [1:0]
  {
    BLK_IDLE = 2'b01,
    BLK_RUN = 2'b10
  } cstob_blk_state_t;

endpackage

/* design/cstob_top.sv */
`timescale 1ns/1ps
module cstob_top
(
  // clock, reset, enable
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CE,
  // avalon-mm slave
  input wire logic [cstob_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // sense results from the converter front end (same clock)
  input wire logic [7:0] I_LOCAL_VOLTAGE_SENSE,
  input wire logic [7:0] I_REMOTE_VOLTAGE_SENSE,
  input wire logic [7:0] I_SECONDARY_CURRENT_SENSE,
  // pwm outputs watched for cycle start (pins)
  input wire logic I_PWM_OUTPUT_SECOND,
  input wire logic I_PWM_OUTPUT_FOURTH,
  input wire logic I_PWM_OUTPUT_AUXILIARY,
  // to current sense front end and comparator
  output logic O_PRIMARY_GAIN_NEGATIVE,
  output logic [6:0] O_PRIMARY_GAIN_MAGNITUDE,
  output logic O_OCP_FAST_ENABLE,
  output logic [7:0] O_OCP_PRECISE_LIMIT
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // cycles for a least time: round up, never below one
  function automatic logic [5:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + cstob_pkg::CLK_PERIOD_NS - 1) / cstob_pkg::CLK_PERIOD_NS;
    if (c < 1)
      c = 1;
    return c[5:0];
  endfunction

  // register index from byte address; the low two bits are ignored
  function automatic logic [7:0] word_idx(input logic [cstob_pkg::ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r; // two-stage sync plus history
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
    begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
    end
    else if (I_CE)
    begin
      pin_s1_r <= {I_PWM_OUTPUT_AUXILIARY, I_PWM_OUTPUT_FOURTH, I_PWM_OUTPUT_SECOND};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  logic [2:0] rise; // rising edges of the synchronised pwm lines
  assign rise = pin_s2_r & ~pin_s3_r;

  // ---------------------------------------------------------------
  // register file state
  // ---------------------------------------------------------------
  cstob_pkg::cstob_trim_t trim_r, trim_nxt; // gain trim register
  logic [7:0] ocp_r, ocp_nxt; // precise limit plus blanking code
  logic [7:0] ctrl_r, ctrl_nxt; // own control: aux pwm in use
  logic [7:0] imp_r, imp_nxt; // latest impedance result
  logic [31:0] rdata_r, rdata_nxt; // read data register
  logic wait_r, wait_nxt; // waitrequest, low for one cycle to answer
  logic div_start_r, div_start_nxt; // kicks a division

  logic [7:0] div_q; // divider quotient
  logic div_done; // divider finished
  logic [7:0] diff; // local minus remote, clamped at zero
  logic [1:0] blk_state_v; // state bits for status readback
  logic req; // bus request present

  assign req = I_AVS_READ | I_AVS_WRITE;
  assign diff = (I_LOCAL_VOLTAGE_SENSE > I_REMOTE_VOLTAGE_SENSE) ?
                (I_LOCAL_VOLTAGE_SENSE - I_REMOTE_VOLTAGE_SENSE) : 8'h00;

  // ---------------------------------------------------------------
  // impedance divider
  // ---------------------------------------------------------------
  cstob_divider u_div
  (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RESET_N),
    .i_ce(I_CE),
    .i_start(div_start_r),
    .i_num(diff),
    .i_den(I_SECONDARY_CURRENT_SENSE),
    .o_quot(div_q),
    .o_done(div_done)
  );

  // ---------------------------------------------------------------
  // bus slave next state: every access answers after one wait cycle
  // ---------------------------------------------------------------
  always_comb
  begin
    trim_nxt = trim_r;
    ocp_nxt = ocp_r;
    ctrl_nxt = ctrl_r;
    imp_nxt = imp_r;
    rdata_nxt = rdata_r;
    wait_nxt = 1'b1;
    // keep a division running continuously
    div_start_nxt = div_done | (div_start_r == 1'b0 && imp_r == 8'h00 && !div_done);
    if (div_done)
      imp_nxt = div_q;
    // answer on the cycle after the request is seen
    if (req && wait_r)
    begin
      wait_nxt = 1'b0;
      rdata_nxt = cstob_pkg::UNMAPPED_DATA;
      unique case (word_idx(I_AVS_ADDRESS))
        cstob_pkg::REG_LINE_IMP_IDX:
          rdata_nxt = {24'h000000, imp_r};
        cstob_pkg::REG_GAIN_TRIM_IDX:
          rdata_nxt = {24'h000000, trim_r};
        cstob_pkg::REG_OCP_LIMIT_IDX:
          rdata_nxt = {24'h000000, ocp_r};
        cstob_pkg::REG_CTRL_IDX:
          rdata_nxt = {24'h000000, ctrl_r};
        cstob_pkg::REG_STATUS_IDX:
          rdata_nxt = {29'h0000000, O_OCP_FAST_ENABLE, blk_state_v};
        default:
          rdata_nxt = cstob_pkg::UNMAPPED_DATA;
      endcase
      if (I_AVS_WRITE)
        rdata_nxt = rdata_r;
    end
    // writes land only at the edge where the master sees waitrequest low
    if (I_AVS_WRITE && !wait_r && I_AVS_BYTEENABLE[0])
    begin
      if (word_idx(I_AVS_ADDRESS) == cstob_pkg::REG_GAIN_TRIM_IDX)
        trim_nxt = I_AVS_WRITEDATA[7:0];
      // blanking code lives in bits 7:5
      if (word_idx(I_AVS_ADDRESS) == cstob_pkg::REG_OCP_LIMIT_IDX)
        ocp_nxt = I_AVS_WRITEDATA[7:0];
      if (word_idx(I_AVS_ADDRESS) == cstob_pkg::REG_CTRL_IDX)
        ctrl_nxt = I_AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
    begin
      trim_r <= cstob_pkg::TRIM_RST;
      ocp_r <= cstob_pkg::OCP_LIMIT_RST;
      ctrl_r <= cstob_pkg::CTRL_RST;
      imp_r <= 8'h00;
      rdata_r <= 32'h00000000;
      wait_r <= 1'b1;
      div_start_r <= 1'b0;
    end
    else if (I_CE)
    begin
      trim_r <= trim_nxt;
      ocp_r <= ocp_nxt;
      ctrl_r <= ctrl_nxt;
      imp_r <= imp_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      div_start_r <= div_start_nxt;
    end
  end

  // ---------------------------------------------------------------
  // blanking timer
  // ---------------------------------------------------------------
  cstob_pkg::cstob_blk_state_t blk_r, blk_nxt; // timer state
  logic [cstob_pkg::CNT_W-1:0] cnt_r, cnt_nxt; // cycles remaining
  logic fast_en_r, fast_en_nxt; // comparator enable
  logic cyc_start; // switching cycle start event
  logic [cstob_pkg::CNT_W-1:0] blank_cyc; // selected interval length

  assign blk_state_v = blk_r;

  // second and fourth pwm rises mark cycle start
  // auxiliary rise replaces them when in use
  assign cyc_start = ctrl_r[cstob_pkg::CTRL_AUX_BIT] ? rise[2] : (rise[0] | rise[1]);

  // code to interval length, code zero means no blanking
  always_comb
  begin
    unique case (ocp_r[7:cstob_pkg::BLANK_LSB])
      3'h0: blank_cyc = 6'h00;
      3'h1: blank_cyc = ns_to_cyc(cstob_pkg::BLANK_NS_1);
      3'h2: blank_cyc = ns_to_cyc(cstob_pkg::BLANK_NS_2);
      3'h3: blank_cyc = ns_to_cyc(cstob_pkg::BLANK_NS_3);
      3'h4: blank_cyc = ns_to_cyc(cstob_pkg::BLANK_NS_4);
      3'h5: blank_cyc = ns_to_cyc(cstob_pkg::BLANK_NS_5);
      3'h6: blank_cyc = ns_to_cyc(cstob_pkg::BLANK_NS_6);
      3'h7: blank_cyc = ns_to_cyc(cstob_pkg::BLANK_NS_7);
    endcase
  end

  // restart on each cycle start, re-enable when elapsed
  always_comb
  begin
    blk_nxt = blk_r;
    cnt_nxt = cnt_r;
    fast_en_nxt = fast_en_r;
    unique case (blk_r)
      cstob_pkg::BLK_IDLE:
      begin
        fast_en_nxt = 1'b1;
        // a zero code never blanks
        if (cyc_start && blank_cyc != 6'h00)
        begin
          blk_nxt = cstob_pkg::BLK_RUN;
          cnt_nxt = blank_cyc;
          fast_en_nxt = 1'b0;
        end
      end
      cstob_pkg::BLK_RUN:
      begin
        fast_en_nxt = 1'b0;
        if (cyc_start)
          cnt_nxt = blank_cyc;
        else if (cnt_r <= 6'h01)
        begin
          blk_nxt = cstob_pkg::BLK_IDLE;
          cnt_nxt = 6'h00;
          fast_en_nxt = 1'b1;
        end
        else
          cnt_nxt = cnt_r - 6'h01;
        if (cyc_start && blank_cyc == 6'h00)
        begin
          blk_nxt = cstob_pkg::BLK_IDLE;
          fast_en_nxt = 1'b1;
        end
      end
      default:
      begin
        blk_nxt = cstob_pkg::BLK_IDLE;
        cnt_nxt = 6'h00;
        fast_en_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESET_N)
    begin
      blk_r <= cstob_pkg::BLK_IDLE;
      cnt_r <= 6'h00;
      fast_en_r <= 1'b1;
    end
    else if (I_CE)
    begin
      blk_r <= blk_nxt;
      cnt_r <= cnt_nxt;
      fast_en_r <= fast_en_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign O_AVS_READDATA = rdata_r;
  assign O_AVS_WAITREQUEST = wait_r;
  // polarity to the sense front end
  assign O_PRIMARY_GAIN_NEGATIVE = trim_r.negative;
  // trim magnitude to the sense front end
  assign O_PRIMARY_GAIN_MAGNITUDE = trim_r.magnitude;
  assign O_OCP_FAST_ENABLE = fast_en_r;
  assign O_OCP_PRECISE_LIMIT = ocp_r;

endmodule

/* tb/cstob_checker.sv */
`timescale 1ns/1ps
module cstob_checker
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  // register bus
  input wire logic [cstob_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  // sense and pwm pins
  input wire logic [7:0] I_LOCAL_VOLTAGE_SENSE,
  input wire logic [7:0] I_REMOTE_VOLTAGE_SENSE,
  input wire logic [7:0] I_SECONDARY_CURRENT_SENSE,
  input wire logic I_PWM_OUTPUT_SECOND,
  input wire logic I_PWM_OUTPUT_FOURTH,
  input wire logic I_PWM_OUTPUT_AUXILIARY,
  // outputs under watch
  input wire logic O_PRIMARY_GAIN_NEGATIVE,
  input wire logic [6:0] O_PRIMARY_GAIN_MAGNITUDE,
  input wire logic O_OCP_FAST_ENABLE,
  input wire logic [7:0] O_OCP_PRECISE_LIMIT
);
  // answered access, register index and accepted write
  wire ans = !O_AVS_WAITREQUEST && (I_AVS_READ || I_AVS_WRITE);
  wire [7:0] idx = I_AVS_ADDRESS[9:2];
  wire wt = ans && I_AVS_WRITE && I_AVS_BYTEENABLE[0];
  wire [2:0] code = O_OCP_PRECISE_LIMIT[7:5];
  logic [5:0] low_cnt; // run of blanked cycles
  logic [5:0] stab; // cycles the sense inputs held still
  logic [23:0] sense_q;
  logic aux_r; // mirror of the aux-in-use control bit
  logic [7:0] wd_r;
  function automatic logic [5:0] cyc(input logic [2:0] c);
    case (c)
      3'h0: return 6'h00;
      3'h1: return 6'h02;
      3'h2: return 6'h04;
      3'h3: return 6'h05;
      3'h4: return 6'h08;
      3'h5: return 6'h10;
      3'h6: return 6'h18;
      default: return 6'h20;
    endcase
  endfunction
  function automatic logic [7:0] imp(input logic [7:0] l, input logic [7:0] r, input logic [7:0] c);
    if (c == 8'h00) return 8'hFF;
    return (l > r) ? 8'((l - r) / c) : 8'h00;
  endfunction
  // helper state; a slow divider is only judged after the inputs settle
  always_ff @(posedge I_CORE_CLK)
  begin
    sense_q <= {I_LOCAL_VOLTAGE_SENSE, I_REMOTE_VOLTAGE_SENSE, I_SECONDARY_CURRENT_SENSE};
    if (!I_RESET_N)
    begin
      low_cnt <= 6'h00;
      stab <= 6'h00;
      aux_r <= 1'h0;
      wd_r <= 8'h00;
    end
    else
    begin
      low_cnt <= O_OCP_FAST_ENABLE ? 6'h00 : low_cnt + 6'h01;
      stab <= (sense_q != {I_LOCAL_VOLTAGE_SENSE, I_REMOTE_VOLTAGE_SENSE, I_SECONDARY_CURRENT_SENSE}) ? 6'h00 :
        (stab == 6'h3F) ? stab : stab + 6'h01;
      if (wt)
        wd_r <= I_AVS_WRITEDATA[7:0];
      if (wt && idx == 8'h30)
        aux_r <= I_AVS_WRITEDATA[0];
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);
  property p_ans;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_one;
    !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST;
  endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_neg;
    wt && idx == 8'h21 |-> ##2 O_PRIMARY_GAIN_NEGATIVE == wd_r[7];
  endproperty
  a_neg: assert property (p_neg) else $error("gain polarity wrong");
  property p_mag;
    wt && idx == 8'h21 |-> ##2 O_PRIMARY_GAIN_MAGNITUDE == wd_r[6:0];
  endproperty
  a_mag: assert property (p_mag) else $error("gain magnitude wrong");
  property p_lim;
    wt && idx == 8'h22 |-> ##2 O_OCP_PRECISE_LIMIT == wd_r;
  endproperty
  a_lim: assert property (p_lim) else $error("blanking field wrong");
  property p_blank;
    $rose(O_OCP_FAST_ENABLE) |-> low_cnt == cyc(code);
  endproperty
  a_blank: assert property (p_blank) else $error("blanking length wrong");
  property p_sync;
    $rose(I_PWM_OUTPUT_SECOND || I_PWM_OUTPUT_FOURTH) && !aux_r && O_OCP_FAST_ENABLE
      |-> ##[2:4] O_OCP_FAST_ENABLE == (code == 3'h0);
  endproperty
  a_sync: assert property (p_sync) else $error("blanking not started by main pwm");
  property p_aux;
    $rose(I_PWM_OUTPUT_AUXILIARY) && aux_r && O_OCP_FAST_ENABLE && code != 3'h0 |-> ##[2:4] !O_OCP_FAST_ENABLE;
  endproperty
  a_aux: assert property (p_aux) else $error("blanking not started by aux pwm");
  property p_sel;
    $rose(I_PWM_OUTPUT_SECOND) && aux_r && !I_PWM_OUTPUT_AUXILIARY |=> O_OCP_FAST_ENABLE [*5];
  endproperty
  a_sel: assert property (p_sel) else $error("main pwm used in aux mode");
  property p_imp;
    ans && I_AVS_READ && idx == 8'h1F && stab > 6'h1E
      |-> O_AVS_READDATA[7:0] == imp(I_LOCAL_VOLTAGE_SENSE, I_REMOTE_VOLTAGE_SENSE, I_SECONDARY_CURRENT_SENSE);
  endproperty
  a_imp: assert property (p_imp) else $error("impedance result wrong");
  c_long: cover property ($rose(O_OCP_FAST_ENABLE) && low_cnt == 6'h20);
  c_aux: cover property ($rose(I_PWM_OUTPUT_AUXILIARY) && aux_r);
  c_imp: cover property (ans && I_AVS_READ && idx == 8'h1F && stab > 6'h1E);
endmodule
bind cstob_top cstob_checker u_cstob_checker
(
  .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
  .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .I_LOCAL_VOLTAGE_SENSE(I_LOCAL_VOLTAGE_SENSE), .I_REMOTE_VOLTAGE_SENSE(I_REMOTE_VOLTAGE_SENSE),
  .I_SECONDARY_CURRENT_SENSE(I_SECONDARY_CURRENT_SENSE), .I_PWM_OUTPUT_SECOND(I_PWM_OUTPUT_SECOND),
  .I_PWM_OUTPUT_FOURTH(I_PWM_OUTPUT_FOURTH), .I_PWM_OUTPUT_AUXILIARY(I_PWM_OUTPUT_AUXILIARY),
  .O_PRIMARY_GAIN_NEGATIVE(O_PRIMARY_GAIN_NEGATIVE), .O_PRIMARY_GAIN_MAGNITUDE(O_PRIMARY_GAIN_MAGNITUDE),
  .O_OCP_FAST_ENABLE(O_OCP_FAST_ENABLE), .O_OCP_PRECISE_LIMIT(O_OCP_PRECISE_LIMIT)
);

/* tb/cstob_pwm_stage.sv */
`timescale 1ns/1ps
// power stage model: one 40-cycle high pulse on the chosen pwm pin per request
module cstob_pwm_stage
(
  // request
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [1:0] i_sel,
  // pwm pins
  output logic o_second,
  output logic o_fourth,
  output logic o_aux
);
  int cnt = 0;
  logic [1:0] sel_r = 2'h0;
  always @(posedge i_clk)
  begin
    if (i_go)
    begin
      cnt <= 40;
      sel_r <= i_sel;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign o_second = (cnt != 0) && (sel_r == 2'h0);
  assign o_fourth = (cnt != 0) && (sel_r == 2'h1);
  assign o_aux = (cnt != 0) && (sel_r == 2'h2);
endmodule

/* tb/current_sense_trim_ocp_blanking_tb.sv */
`timescale 1ns/1ps
module current_sense_trim_ocp_blanking_tb;
  logic clk = 1'h0, rst_n = 1'h0, rd_en = 1'h0, wr_en = 1'h0, go = 1'h0;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0] ben = 4'h0;
  logic [7:0] lv = 8'h00, rv = 8'h00, cs = 8'h00, lim;
  logic [1:0] sel = 2'h0;
  logic wreq, neg, fast, p2, p4, pa;
  logic [6:0] mag;
  int n_mismatch = 0, cmp_count = 0, cycles = 0;
  int unsigned seed = 54057;
  int tbl[8] = '{0, 2, 4, 5, 8, 16, 24, 32};
  logic [31:0] rd;
  logic [7:0] v, m, tv;
  cstob_top u_cstob_top (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_CE(1'h1), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(ben),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq), .I_LOCAL_VOLTAGE_SENSE(lv), .I_REMOTE_VOLTAGE_SENSE(rv),
    .I_SECONDARY_CURRENT_SENSE(cs), .I_PWM_OUTPUT_SECOND(p2), .I_PWM_OUTPUT_FOURTH(p4),
    .I_PWM_OUTPUT_AUXILIARY(pa), .O_PRIMARY_GAIN_NEGATIVE(neg), .O_PRIMARY_GAIN_MAGNITUDE(mag),
    .O_OCP_FAST_ENABLE(fast), .O_OCP_PRECISE_LIMIT(lim));
  cstob_pwm_stage u_cstob_pwm_stage (.i_clk(clk), .i_go(go), .i_sel(sel), .o_second(p2), .o_fourth(p4), .o_aux(pa));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be);
    @(posedge clk);
    addr <= {idx, 2'h0};
    wdat <= {24'h0, wd};
    ben <= be;
    rd_en <= !wr;
    wr_en <= wr;
    do @(posedge clk); while (wreq !== 1'h0);
    rd = rdat;
    rd_en <= 1'h0;
    wr_en <= 1'h0;
  endtask
  // one pwm pulse, then count the blanked cycles of the fast comparator
  task automatic blank(input logic [1:0] s, input int exp);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'h1;
    sel <= s;
    @(posedge clk);
    go <= 1'h0;
    repeat (8)
    begin
      @(posedge clk);
      if (fast === 1'h0)
        break;
    end
    while (fast === 1'h0 && n < 40)
    begin
      n++;
      @(posedge clk);
    end
    chk("blank", n, exp);
    repeat (50) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    chk("fast_rst", fast, 1);
    bus(0, 8'h21, 8'h00, 4'hF);
    chk("trim_rst", rd, 0);
    // trim polarity and magnitude, random values
    repeat (8)
    begin
      v = 8'(xs());
      bus(1, 8'h21, v, 4'h1);
      bus(0, 8'h21, 8'h00, 4'hF);
      chk("trim", rd, {24'h0, v});
      chk("gain_neg", neg, v[7]);
      chk("gain_mag", mag, v[6:0]);
    end
    tv = v;
    // every blanking code, main pwm pins alternating
    for (int c = 0; c < 8; c++)
    begin
      v = {3'(c), 5'(xs())};
      bus(1, 8'h22, v, 4'h1);
      // the register is loaded at the answering edge; look one edge later
      @(posedge clk);
      chk("limit", lim, v);
      blank(2'(c % 2), tbl[c]);
    end
    // aux pin in use: aux starts blanking, main pin does not
    bus(1, 8'h30, 8'h01, 4'h1);
    bus(0, 8'h30, 8'h00, 4'hF);
    chk("ctrl", rd, 32'h1);
    blank(2'h2, tbl[7]);
    blank(2'h0, 0);
    bus(1, 8'h30, 8'h00, 4'h1);
    // impedance with clamp and divide by zero
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      lv <= 8'(xs());
      rv <= (i == 1) ? 8'hFF : 8'(xs() % 64);
      cs <= (i == 0) ? 8'h00 : 8'(xs() % 16 + 1);
      repeat (40) @(posedge clk);
      m = (cs == 0) ? 8'hFF : (lv > rv) ? 8'((lv - rv) / cs) : 8'h00;
      bus(0, 8'h1F, 8'h00, 4'hF);
      chk("impedance", rd, {24'h0, m});
    end
    // refused accesses: read-only write, no byte enable, unmapped read
    bus(1, 8'h1F, 8'h5A, 4'h1);
    bus(0, 8'h1F, 8'h00, 4'hF);
    chk("imp_ro", rd, {24'h0, m});
    bus(1, 8'h21, ~tv, 4'hE);
    @(posedge clk);
    chk("gain_be", {neg, mag}, tv);
    bus(0, 8'h05, 8'h00, 4'hF);
    chk("unmapped", rd, 0);
    // idle timer: fast comparator on, state idle
    bus(0, 8'h31, 8'h00, 4'hF);
    chk("status", rd, 32'h5);
    end_of_test();
  end
endmodule
